/* sim/pcs_link_lock_control_tb.sv */
/*
 * Self-checking bench for the lock control block: register file over APB,
 * idle lock, error loss, gap checking, link control, interleave and sleep timer.
 * Assumes the designer's one-wait-state APB slave and shortened sleep timer counts.
 */
`timescale 1ns/1ps
`default_nettype none

module pcs_link_lock_control_tb;
	import plc_pkg::*;
	localparam int L0 = 10;
	localparam int L1 = 25;
	localparam int L2 = 100;
	localparam int L3 = 200;
	logic clk, nrst, psel, penable, pwrite, pready, pslverr, sleep_request;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic sym_valid, sym_idle, sym_error, rx_in_gap, rx_interleave_seen;
	logic training_enable, link_up, remote_rx_ok, coding_sleep_enable;
	logic tx_interleave, interleave_detect_on, sleep_timer_busy, sleep_timer_done;
	int n_mismatch = 0;
	int n_checks = 0;
	int n_cyc = 0;
	int n_done = 0;
	int lens[4] = '{L0, L1, L2, L3};

	plc_link_lock #(.ADDR_W(16), .SLEEP_CYC_SEL0(L0), .SLEEP_CYC_SEL1(L1),
		.SLEEP_CYC_SEL2(L2), .SLEEP_CYC_SEL3(L3)) i_dut (.clk(clk), .nrst(nrst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sym_valid(sym_valid), .sym_idle(sym_idle), .sym_error(sym_error),
		.rx_in_gap(rx_in_gap), .rx_interleave_seen(rx_interleave_seen),
		.sleep_request(sleep_request), .training_enable(training_enable),
		.link_up(link_up), .remote_rx_ok(remote_rx_ok),
		.coding_sleep_enable(coding_sleep_enable), .tx_interleave(tx_interleave),
		.interleave_detect_on(interleave_detect_on), .sleep_timer_busy(sleep_timer_busy),
		.sleep_timer_done(sleep_timer_done));

	plc_link_partner p (.clk(clk), .sym_valid(sym_valid), .sym_idle(sym_idle),
		.sym_error(sym_error), .rx_in_gap(rx_in_gap), .rx_interleave_seen(rx_interleave_seen));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// A hang anywhere ends the run here rather than leaving it spinning.
	always @(posedge clk) begin
		n_cyc = n_cyc + 1;
		if (sleep_timer_done === 1'b1) begin
			n_done = n_done + 1;
		end
		if (n_cyc == 20000) begin
			n_mismatch = n_mismatch + 1;
			close_out();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic flags(input logic [1:0] exp);
		chk({30'h0, link_up, remote_rx_ok}, {30'h0, exp});
	endtask

	task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			n_mismatch++;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] idx, input logic [31:0] d);
		logic [31:0] rd;
		logic e;
		apb(1'b1, idx, d, rd, e);
	endtask

	task automatic rdc(input logic [11:0] idx, input logic [31:0] exp, input logic experr);
		logic [31:0] rd;
		logic e;
		apb(1'b0, idx, 32'h0, rd, e);
		chk(rd, exp);
		chk({31'h0, e}, {31'h0, experr});
	endtask

	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic req_pulse();
		@(posedge clk);
		sleep_request <= 1'b1;
		@(posedge clk);
		sleep_request <= 1'b0;
	endtask

	task automatic t_reset();
		chk(32'({training_enable, interleave_detect_on, coding_sleep_enable}), 32'h6);
		rdc(IDX_PCS_CONTROL_ONE, 32'h1078, 1'b0);
		rdc(IDX_PCS_CONTROL_TWO, 32'h1405, 1'b0);
		rdc(IDX_SLEEP_CONTROL_TWO, 32'h0A00, 1'b0);
		rdc(IDX_INTERLEAVE_CONFIG, 32'h0001, 1'b0);
		rdc(IDX_SLEEP_CONTROL_THREE, 32'h0014, 1'b0);
		rdc(12'h488, 32'h0, 1'b1);
		wr(IDX_INTERLEAVE_CONFIG, 32'hFFFF);
		rdc(IDX_INTERLEAVE_CONFIG, 32'h0007, 1'b0);
		wr(IDX_INTERLEAVE_CONFIG, 32'h0001);
		$display("test reset finished");
	endtask

	task automatic t_lock_loss();
		wr(IDX_PCS_CONTROL_ONE, 32'h1E03);
		rdc(IDX_PCS_CONTROL_ONE, 32'h1003, 1'b0);
		p.send(2, 1'b1, 1'b0, 0);
		p.send(1, 1'b0, 1'b0, 0);
		p.send(2, 1'b1, 1'b0, 1);
		settle();
		flags(2'b00);
		p.send(1, 1'b1, 1'b0, 0);
		settle();
		flags(2'b11);
		wr(IDX_PCS_CONTROL_TWO, 32'h0802);
		p.send(1, 1'b0, 1'b0, 0);
		settle();
		flags(2'b11);
		p.send(2, 1'b0, 1'b0, 2);
		settle();
		flags(2'b10);
		p.send(1, 1'b0, 1'b0, 0);
		settle();
		flags(2'b00);
		p.send(3, 1'b1, 1'b0, 0);
		p.send(3, 1'b0, 1'b0, 0);
		settle();
		flags(2'b10);
		p.send(1, 1'b0, 1'b0, 0);
		settle();
		flags(2'b00);
		$display("test lock and loss finished");
	endtask

	task automatic t_gap_ctl();
		p.send(3, 1'b1, 1'b0, 0);
		wr(IDX_PCS_CONTROL_ONE, 32'h3003);
		p.send(5, 1'b0, 1'b1, 0);
		settle();
		flags(2'b11);
		wr(IDX_PCS_CONTROL_ONE, 32'h1003);
		p.send(4, 1'b0, 1'b1, 0);
		settle();
		flags(2'b00);
		p.send(3, 1'b1, 1'b0, 0);
		wr(IDX_PCS_CONTROL_ONE, 32'h0003);
		settle();
		chk(32'(training_enable), 32'h0);
		flags(2'b00);
		p.send(3, 1'b1, 1'b0, 0);
		settle();
		flags(2'b00);
		wr(IDX_PCS_CONTROL_ONE, 32'h1003);
		p.send(2, 1'b1, 1'b0, 0);
		settle();
		flags(2'b00);
		p.send(1, 1'b1, 1'b0, 0);
		settle();
		flags(2'b11);
		$display("test gap and link control finished");
	endtask

	task automatic t_interleave();
		p.pulse_interleave();
		settle();
		chk(32'(tx_interleave), 32'h0);
		wr(IDX_INTERLEAVE_CONFIG, 32'h0003);
		settle();
		chk(32'(tx_interleave), 32'h1);
		rdc(IDX_LOCK_STATUS, 32'h000F, 1'b0);
		wr(IDX_INTERLEAVE_CONFIG, 32'h0002);
		settle();
		chk(32'({tx_interleave, interleave_detect_on}), 32'h0);
		wr(IDX_INTERLEAVE_CONFIG, 32'h0004);
		settle();
		chk(32'(tx_interleave), 32'h1);
		wr(IDX_INTERLEAVE_CONFIG, 32'h0001);
		settle();
		chk(32'(tx_interleave), 32'h0);
		$display("test interleave finished");
	endtask

	task automatic t_sleep();
		int c;
		int k;
		int d0;
		wr(IDX_SLEEP_CONTROL_TWO, 32'h0A01);
		settle();
		chk(32'(coding_sleep_enable), 32'h1);
		for (int s = 0; s < 4; s++) begin
			wr(IDX_SLEEP_CONTROL_THREE, {26'h0, 2'(s), 4'h4});
			req_pulse();
			c = 0;
			k = 0;
			while (sleep_timer_done !== 1'b1 && k < 400) begin
				@(negedge clk);
				k++;
				if (sleep_timer_busy === 1'b1 && sleep_timer_done !== 1'b1) begin
					c++;
				end
			end
			chk(32'(c), 32'(lens[s]));
		end
		wr(IDX_SLEEP_CONTROL_THREE, 32'h0014);
		d0 = n_done;
		req_pulse();
		wr(IDX_SLEEP_CONTROL_TWO, 32'h0A00);
		repeat (40) @(posedge clk);
		#1;
		chk(32'({sleep_timer_busy, coding_sleep_enable}), 32'h0);
		chk(32'(n_done - d0), 32'h0);
		req_pulse();
		settle();
		chk(32'(sleep_timer_busy), 32'h0);
		$display("test sleep timer finished");
	endtask

	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0;
		pwdata = 32'h0;
		pstrb = 4'hF;
		sleep_request = 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_lock_loss();
		t_gap_ctl();
		t_interleave();
		t_sleep();
		close_out();
	end
endmodule

`default_nettype wire

/* sim/plc_link_partner.sv */
/*
 * Behavioural link partner: delivers received symbols and receive-path flags
 * to the lock control block.
 * Assumes the bench calls its tasks and that it shares the block's clock.
 */
`timescale 1ns/1ps
`default_nettype none

module plc_link_partner (
	input wire logic clk,
	output logic sym_valid,
	output logic sym_idle,
	output logic sym_error,
	output logic rx_in_gap,
	output logic rx_interleave_seen
);
	initial begin
		sym_valid = 1'b0;
		sym_idle = 1'b0;
		sym_error = 1'b1;
		rx_in_gap = 1'b0;
		rx_interleave_seen = 1'b0;
	end

	// Between symbols the qualifiers show the inverse of the last symbol, so a
	// block that looks at them without the valid strobe sees the wrong kind.
	// A nonzero space makes the partner slow, with gaps between symbols.
	task automatic send(input int n, input logic idle, input logic gap, input int space);
		repeat (n) begin
			@(posedge clk);
			sym_valid <= 1'b1;
			sym_idle <= idle;
			sym_error <= ~idle;
			rx_in_gap <= gap;
			repeat (space) begin
				@(posedge clk);
				sym_valid <= 1'b0;
				sym_idle <= ~idle;
				sym_error <= idle;
			end
		end
		@(posedge clk);
		sym_valid <= 1'b0;
		sym_idle <= ~idle;
		sym_error <= idle;
		rx_in_gap <= ~gap;
	endtask

	task automatic pulse_interleave();
		@(posedge clk);
		rx_interleave_seen <= 1'b1;
		@(posedge clk);
		rx_interleave_seen <= 1'b0;
	endtask
endmodule

`default_nettype wire

/* src/dummy_unused_never.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* src/plc_link_lock.sv */
/*
 * Link lock control for the physical coding sublayer: APB register file,
 * idle-symbol lock counting, error-symbol loss of lock, remote receiver
 * status, interleave control and the sleep request timer.
 * Assumes symbol inputs come from datapath logic on the same clock, one
 * symbol per sym_valid pulse, and an APB master that holds its request.
 */
// The APB register port was left to the implementer.
// Behaviour
// RULE_01: A set gap-check-disable bit stops error symbols inside the inter-packet gap from counting.
// RULE_02: Training and link-up may proceed only while the link control bit is one, its reset value.
// RULE_03: Lock and link are declared after the configured number of idle symbols, default 120.
// RULE_04: Lock and link are dropped after the configured number of error symbols, default 10.
// RULE_05: Remote receiver status goes low after the configured number of error symbols, default 5.
// RULE_06: Sleep code-groups are handled only while the coding sleep enable bit is one, reset zero.
// RULE_07: A set force-interleave bit turns transmit interleaving on unconditionally.
// RULE_08: A set interleave enable bit turns transmit interleaving on once receive interleave is seen.
// RULE_09: Receive interleave detection runs only while its enable bit is one, its reset value.
// RULE_10: The sleep request timer lasts 0.4, 1, 4 or 8 ms as selected, with 1 ms after reset.
// RULE_11: Lock and error counters restart from zero when link control is cleared or link is lost.
`timescale 1ns/1ps
`default_nettype none

module plc_link_lock #(
	parameter int ADDR_W = 16,
	parameter int TMR_W = 18,
	parameter int SLEEP_CYC_SEL0 = plc_pkg::SLEEP_CYC_0,
	parameter int SLEEP_CYC_SEL1 = plc_pkg::SLEEP_CYC_1,
	parameter int SLEEP_CYC_SEL2 = plc_pkg::SLEEP_CYC_2,
	parameter int SLEEP_CYC_SEL3 = plc_pkg::SLEEP_CYC_3
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sym_valid,
	input wire logic sym_idle,
	input wire logic sym_error,
	input wire logic rx_in_gap,
	input wire logic rx_interleave_seen,
	input wire logic sleep_request,
	output logic training_enable,
	output logic link_up,
	output logic remote_rx_ok,
	output logic coding_sleep_enable,
	output logic tx_interleave,
	output logic interleave_detect_on,
	output logic sleep_timer_busy,
	output logic sleep_timer_done
);
	import plc_pkg::*;

	logic rst_meta_q;
	logic rst_n;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [15:0] pcs_control_one_q;
	logic [15:0] pcs_control_two_q;
	logic [15:0] sleep_control_two_q;
	logic [15:0] interleave_config_q;
	logic [15:0] sleep_control_three_q;
	logic [11:0] reg_idx;
	logic reg_hit;
	logic [15:0] rd_word;
	logic access_done;
	logic wr_en;
	plc_lock_state_t state_q;
	logic link_up_q;
	logic remote_ok_q;
	logic [8:0] idle_cnt_q;
	logic [4:0] err_cnt_q;
	logic [4:0] rr_cnt_q;
	logic ilv_seen_q;
	logic tx_ilv_q;
	logic training_q;
	logic sleep_en_q;
	logic ilv_det_on_q;
	logic tmr_busy_q;
	logic tmr_done_q;
	logic [TMR_W-1:0] tmr_cnt_q;
	logic [TMR_W-1:0] tmr_lim_q;
	logic [TMR_W-1:0] tmr_lim_sel;
	logic link_ctrl;
	logic gap_check_off;
	logic [8:0] idle_cfg;
	logic [4:0] err_cfg;
	logic [4:0] rr_cfg;
	logic counted_err;
	logic idle_reached;
	logic err_reached;
	logic rr_reached;
	logic tmr_start;

	// Reset is released through two flops so that deassertion is synchronous.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] strb, input logic [15:0] mask);
		logic [15:0] lane;
		logic [15:0] nw;
		lane = {{8{strb[1]}}, {8{strb[0]}}} & mask;
		nw = (old & ~lane) | (wd[15:0] & lane);
		return nw;
	endfunction

	assign reg_idx = paddr[13:2];
	assign access_done = psel && penable && pready_q;
	assign wr_en = access_done && pwrite && reg_hit;

	always_comb begin
		reg_hit = 1'b1;
		rd_word = 16'h0000;
		case (reg_idx)
			IDX_PCS_CONTROL_ONE: rd_word = pcs_control_one_q;
			IDX_PCS_CONTROL_TWO: rd_word = pcs_control_two_q;
			IDX_SLEEP_CONTROL_TWO: rd_word = sleep_control_two_q;
			IDX_INTERLEAVE_CONFIG: rd_word = interleave_config_q;
			IDX_SLEEP_CONTROL_THREE: rd_word = sleep_control_three_q;
			IDX_LOCK_STATUS: rd_word = {11'h000, tmr_busy_q, ilv_seen_q, tx_ilv_q,
				remote_ok_q, link_up_q};
			default: reg_hit = 1'b0;
		endcase
	end

	// One wait state: pready rises in the second access cycle, and drops again after it.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= psel && penable && !pready_q;
			pslverr_q <= psel && penable && !pready_q && !reg_hit;
			if (psel && penable && !pready_q && !pwrite) begin
				prdata_q <= {16'h0000, rd_word};
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pcs_control_one_q <= RST_PCS_CONTROL_ONE;
			pcs_control_two_q <= RST_PCS_CONTROL_TWO;
			sleep_control_two_q <= RST_SLEEP_CONTROL_TWO;
			interleave_config_q <= RST_INTERLEAVE_CONFIG;
			sleep_control_three_q <= RST_SLEEP_CONTROL_THREE;
		end else if (wr_en) begin
			case (reg_idx)
				IDX_PCS_CONTROL_ONE: pcs_control_one_q <= merge(pcs_control_one_q, pwdata,
					pstrb, WMASK_PCS_CONTROL_ONE);
				IDX_PCS_CONTROL_TWO: pcs_control_two_q <= merge(pcs_control_two_q, pwdata,
					pstrb, WMASK_FULL);
				IDX_SLEEP_CONTROL_TWO: sleep_control_two_q <= merge(sleep_control_two_q, pwdata,
					pstrb, WMASK_FULL);
				IDX_INTERLEAVE_CONFIG: interleave_config_q <= merge(interleave_config_q, pwdata,
					pstrb, WMASK_INTERLEAVE_CONFIG);
				IDX_SLEEP_CONTROL_THREE: sleep_control_three_q <= merge(sleep_control_three_q,
					pwdata, pstrb, WMASK_FULL);
				default: begin
				end
			endcase
		end
	end

	assign link_ctrl = pcs_control_one_q[LINK_CONTROL_BIT];
	assign gap_check_off = pcs_control_one_q[IPG_CHECK_OFF_BIT];
	assign idle_cfg = pcs_control_one_q[IDLE_LOCK_LSB +: 9];
	assign err_cfg = pcs_control_two_q[ERR_LOSS_LSB +: 5];
	assign rr_cfg = pcs_control_two_q[REMOTE_ERR_LSB +: 5];

	// Errors inside the gap are ignored when the gap check is off. RULE_01
	assign counted_err = sym_valid && sym_error && !sym_idle && !(rx_in_gap && gap_check_off);
	assign idle_reached = ({1'b0, idle_cnt_q} + 10'h001) >= {1'b0, idle_cfg}; // RULE_03
	assign err_reached = ({1'b0, err_cnt_q} + 6'h01) >= {1'b0, err_cfg}; // RULE_04
	assign rr_reached = ({1'b0, rr_cnt_q} + 6'h01) >= {1'b0, rr_cfg}; // RULE_05

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= LK_SEARCH;
			link_up_q <= 1'b0;
			idle_cnt_q <= 9'h000;
			err_cnt_q <= 5'h00;
		end else begin
			case (state_q)
				LK_SEARCH: begin
					err_cnt_q <= 5'h00;
					if (!link_ctrl) begin
						idle_cnt_q <= 9'h000; // RULE_02
					end else if (sym_valid && sym_idle) begin
						if (idle_reached) begin
							state_q <= LK_LOCKED; // RULE_03
							link_up_q <= 1'b1;
							idle_cnt_q <= 9'h000;
						end else begin
							idle_cnt_q <= idle_cnt_q + 9'h001;
						end
					end else if (sym_valid) begin
						idle_cnt_q <= 9'h000;
					end
				end
				LK_LOCKED: begin
					if (!link_ctrl) begin
						state_q <= LK_SEARCH; // RULE_02
						link_up_q <= 1'b0;
						err_cnt_q <= 5'h00; // RULE_11
					end else if (counted_err) begin
						if (err_reached) begin
							state_q <= LK_SEARCH; // RULE_04
							link_up_q <= 1'b0;
							err_cnt_q <= 5'h00; // RULE_11
						end else begin
							err_cnt_q <= err_cnt_q + 5'h01;
						end
					end
				end
				default: begin
					state_q <= LK_SEARCH;
					link_up_q <= 1'b0;
				end
			endcase
		end
	end

	// Remote status is only meaningful with lock, so it is low while searching.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			remote_ok_q <= 1'b0;
			rr_cnt_q <= 5'h00;
		end else if (state_q != LK_LOCKED || !link_ctrl) begin
			remote_ok_q <= (state_q == LK_SEARCH) && link_ctrl && sym_valid && sym_idle &&
				idle_reached;
			rr_cnt_q <= 5'h00; // RULE_11
		end else if (counted_err && err_reached) begin
			remote_ok_q <= 1'b0;
			rr_cnt_q <= 5'h00; // RULE_11
		end else if (counted_err && remote_ok_q) begin
			if (rr_reached) begin
				remote_ok_q <= 1'b0; // RULE_05
			end else begin
				rr_cnt_q <= rr_cnt_q + 5'h01;
			end
		end
	end

	// The detected flag is held until detection is turned off or lock is lost.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ilv_seen_q <= 1'b0;
			tx_ilv_q <= 1'b0;
			ilv_det_on_q <= 1'b1;
		end else begin
			ilv_det_on_q <= interleave_config_q[INTERLEAVE_DETECT_BIT];
			if (!interleave_config_q[INTERLEAVE_DETECT_BIT] || !link_up_q) begin
				ilv_seen_q <= 1'b0; // RULE_09
			end else if (rx_interleave_seen) begin
				ilv_seen_q <= 1'b1; // RULE_09
			end
			tx_ilv_q <= interleave_config_q[FORCE_INTERLEAVE_BIT] || // RULE_07
				(interleave_config_q[INTERLEAVE_ENABLE_BIT] && ilv_seen_q); // RULE_08
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			training_q <= 1'b1;
			sleep_en_q <= 1'b0;
		end else begin
			training_q <= link_ctrl; // RULE_02
			sleep_en_q <= sleep_control_two_q[CODING_SLEEP_ENABLE_BIT]; // RULE_06
		end
	end

	always_comb begin
		case (sleep_control_three_q[SLEEP_TIMER_SEL_LSB +: 2])
			2'h0: tmr_lim_sel = TMR_W'(SLEEP_CYC_SEL0); // RULE_10
			2'h1: tmr_lim_sel = TMR_W'(SLEEP_CYC_SEL1);
			2'h2: tmr_lim_sel = TMR_W'(SLEEP_CYC_SEL2);
			default: tmr_lim_sel = TMR_W'(SLEEP_CYC_SEL3);
		endcase
	end

	// The duration is latched at start, so a rewrite only affects the next request.
	assign tmr_start = sleep_request && sleep_control_two_q[CODING_SLEEP_ENABLE_BIT] &&
		!tmr_busy_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tmr_busy_q <= 1'b0;
			tmr_done_q <= 1'b0;
			tmr_cnt_q <= '0;
			tmr_lim_q <= '0;
		end else begin
			tmr_done_q <= 1'b0;
			if (!sleep_control_two_q[CODING_SLEEP_ENABLE_BIT]) begin
				tmr_busy_q <= 1'b0; // RULE_06
				tmr_cnt_q <= '0;
			end else if (tmr_start) begin
				tmr_busy_q <= 1'b1;
				tmr_cnt_q <= '0;
				tmr_lim_q <= tmr_lim_sel; // RULE_10
			end else if (tmr_busy_q) begin
				if (tmr_cnt_q == tmr_lim_q - TMR_W'(1)) begin
					tmr_busy_q <= 1'b0; // RULE_10
					tmr_done_q <= 1'b1;
				end else begin
					tmr_cnt_q <= tmr_cnt_q + TMR_W'(1);
				end
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign training_enable = training_q;
	assign link_up = link_up_q;
	assign remote_rx_ok = remote_ok_q;
	assign coding_sleep_enable = sleep_en_q;
	assign tx_interleave = tx_ilv_q;
	assign interleave_detect_on = ilv_det_on_q;
	assign sleep_timer_busy = tmr_busy_q;
	assign sleep_timer_done = tmr_done_q;

	property p_gap_skip;
		@(posedge clk) disable iff (!rst_n)
		(state_q == LK_LOCKED && link_ctrl && sym_valid && sym_error && rx_in_gap &&
			gap_check_off) |=> $stable(err_cnt_q) && link_up_q;
	endproperty
	a_gap_skip: assert property (p_gap_skip) else $error("gap error counted"); // RULE_01

	property p_train_off;
		@(posedge clk) disable iff (!rst_n)
		!link_ctrl |=> !link_up_q && idle_cnt_q == 9'h000 && !training_enable;
	endproperty
	a_train_off: assert property (p_train_off) else $error("link while disabled"); // RULE_02

	property p_lock;
		@(posedge clk) disable iff (!rst_n)
		(state_q == LK_SEARCH && link_ctrl && sym_valid && sym_idle) |=>
			(link_up_q == $past(idle_reached));
	endproperty
	a_lock: assert property (p_lock) else $error("lock at wrong idle count"); // RULE_03

	property p_loss;
		@(posedge clk) disable iff (!rst_n)
		(state_q == LK_LOCKED && link_ctrl && counted_err && err_cnt_q == err_cfg - 5'h01) |=>
			!link_up_q ##1 !link_up_q;
	endproperty
	a_loss: assert property (p_loss) else $error("lock not lost"); // RULE_04

	property p_remote;
		@(posedge clk) disable iff (!rst_n)
		(state_q == LK_LOCKED && link_ctrl && counted_err && remote_ok_q && rr_reached) |=>
			!remote_rx_ok;
	endproperty
	a_remote: assert property (p_remote) else $error("remote status stays high"); // RULE_05

	property p_sleep_gate;
		@(posedge clk) disable iff (!rst_n)
		!sleep_control_two_q[CODING_SLEEP_ENABLE_BIT] |=> !sleep_timer_busy && !coding_sleep_enable;
	endproperty
	a_sleep_gate: assert property (p_sleep_gate) else $error("sleep active while off"); // RULE_06

	property p_force;
		@(posedge clk) disable iff (!rst_n)
		interleave_config_q[FORCE_INTERLEAVE_BIT] |=> tx_interleave;
	endproperty
	a_force: assert property (p_force) else $error("forced interleave missing"); // RULE_07

	property p_ilv_enable;
		@(posedge clk) disable iff (!rst_n)
		!interleave_config_q[FORCE_INTERLEAVE_BIT] |=>
			(tx_interleave == ($past(interleave_config_q[INTERLEAVE_ENABLE_BIT]) &&
			$past(ilv_seen_q)));
	endproperty
	a_ilv_enable: assert property (p_ilv_enable) else $error("interleave enable wrong"); // RULE_08

	property p_detect;
		@(posedge clk) disable iff (!rst_n)
		(!interleave_config_q[INTERLEAVE_DETECT_BIT] && !interleave_config_q[FORCE_INTERLEAVE_BIT])
			|=> !ilv_seen_q ##1 (!tx_interleave || $past(interleave_config_q[FORCE_INTERLEAVE_BIT]));
	endproperty
	a_detect: assert property (p_detect) else $error("detection while off"); // RULE_09

	property p_timer;
		@(posedge clk) disable iff (!rst_n)
		sleep_timer_done |-> $past(tmr_cnt_q) == tmr_lim_q - TMR_W'(1) && !sleep_timer_busy;
	endproperty
	a_timer: assert property (p_timer) else $error("sleep timer length wrong"); // RULE_10

	property p_restart;
		@(posedge clk) disable iff (!rst_n)
		$fell(link_up_q) |-> err_cnt_q == 5'h00 && rr_cnt_q == 5'h00 && idle_cnt_q == 9'h000;
	endproperty
	a_restart: assert property (p_restart) else $error("counters not restarted"); // RULE_11

endmodule

`default_nettype wire

/* src/plc_pkg.sv */
/*
 * Shared constants for the coding-sublayer link lock control block: register
 * indices, field positions, reset values and sleep request timer durations.
 * Assumes a 25 MHz system clock and a 32-bit APB register bus.
 */
package plc_pkg;

	// Register indices; the byte address of each register is four times its index.
	localparam logic [11:0] IDX_PCS_CONTROL_ONE = 12'h485;
	localparam logic [11:0] IDX_PCS_CONTROL_TWO = 12'h486;
	localparam logic [11:0] IDX_SLEEP_CONTROL_TWO = 12'h487;
	localparam logic [11:0] IDX_INTERLEAVE_CONFIG = 12'h489;
	localparam logic [11:0] IDX_SLEEP_CONTROL_THREE = 12'h493;
	localparam logic [11:0] IDX_LOCK_STATUS = 12'h48F;

	// Reset values.
	localparam logic [15:0] RST_PCS_CONTROL_ONE = 16'h1078;
	localparam logic [15:0] RST_PCS_CONTROL_TWO = 16'h1405;
	localparam logic [15:0] RST_SLEEP_CONTROL_TWO = 16'h0A00;
	localparam logic [15:0] RST_INTERLEAVE_CONFIG = 16'h0001;
	localparam logic [15:0] RST_SLEEP_CONTROL_THREE = 16'h0014;

	// Writable bit masks; the other bits are read-only.
	localparam logic [15:0] WMASK_PCS_CONTROL_ONE = 16'hF1FF;
	localparam logic [15:0] WMASK_FULL = 16'hFFFF;
	localparam logic [15:0] WMASK_INTERLEAVE_CONFIG = 16'h0007;

	// Field positions.
	localparam int IPG_CHECK_OFF_BIT = 13;
	localparam int LINK_CONTROL_BIT = 12;
	localparam int IDLE_LOCK_LSB = 0;
	localparam int ERR_LOSS_LSB = 9;
	localparam int REMOTE_ERR_LSB = 0;
	localparam int CODING_SLEEP_ENABLE_BIT = 0;
	localparam int FORCE_INTERLEAVE_BIT = 2;
	localparam int INTERLEAVE_ENABLE_BIT = 1;
	localparam int INTERLEAVE_DETECT_BIT = 0;
	localparam int SLEEP_TIMER_SEL_LSB = 4;

	// Sleep request timer durations in microseconds, and the clock rate.
	localparam int CLK_MHZ = 25;
	localparam int SLEEP_T0_US = 400;
	localparam int SLEEP_T1_US = 1000;
	localparam int SLEEP_T2_US = 4000;
	localparam int SLEEP_T3_US = 8000;
	localparam int SLEEP_CYC_0 = SLEEP_T0_US * CLK_MHZ;
	localparam int SLEEP_CYC_1 = SLEEP_T1_US * CLK_MHZ;
	localparam int SLEEP_CYC_2 = SLEEP_T2_US * CLK_MHZ;
	localparam int SLEEP_CYC_3 = SLEEP_T3_US * CLK_MHZ;

	typedef enum logic {LK_SEARCH, LK_LOCKED} plc_lock_state_t;

endpackage
